//--- hw/ftec_consts.svh
// Constants of the four-track encoder counter
`ifndef FTEC_CONSTS_SVH
`define FTEC_CONSTS_SVH

`define FTEC_CLK_MHZ     100
`define FTEC_GATE_US     1000
`define FTEC_THR_MV      1500
`define FTEC_HYST_MV     500
`define FTEC_RISE_MV     (`FTEC_THR_MV + `FTEC_HYST_MV / 2)
`define FTEC_FALL_MV     (`FTEC_THR_MV - `FTEC_HYST_MV / 2)

`define FTEC_OFS_CTRL    8'h00
`define FTEC_OFS_STAT    8'h04
`define FTEC_CNT_PAGE    4'h1

`define FTEC_CTRL_W      12
`define FTEC_CTRL_RST    12'h000
`define FTEC_B_RUN       0
`define FTEC_B_NOIDX     1
`define FTEC_B_DUAL0     2
`define FTEC_B_MODE      4

`define FTEC_IDX_RST     3'h7

`endif

//--- hw/ftec_pkg.sv
// Types of the four-track encoder counter
package ftec_pkg;

  typedef enum logic [1:0] {
    FTEC_MODE_EVENT = 2'h0,
    FTEC_MODE_FREQ  = 2'h1,
    FTEC_MODE_TIME  = 2'h2,
    FTEC_MODE_RSV   = 2'h3
  } ftec_mode_t;

  typedef enum logic [1:0] {
    FTEC_ST_IDLE = 2'h0,
    FTEC_ST_WAIT = 2'h1,
    FTEC_ST_RUN  = 2'h3
  } ftec_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ftec_apb_req_t;

  typedef struct packed {
    logic [3:0][15:0] trk;
    logic [15:0]      idx;
  } ftec_samples_t;

endpackage

//--- hw/ftec_counter.sv
// Four-track encoder counter with APB register access
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ftec_consts.svh"

module ftec_counter #(
  parameter int unsigned GATE_CYC = `FTEC_GATE_US * `FTEC_CLK_MHZ
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rstn,
  input  wire ftec_pkg::ftec_apb_req_t i_apb,
  input  wire ftec_pkg::ftec_samples_t i_smp,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr
);

  localparam int NCH = 4;

  logic [`FTEC_CTRL_W-1:0] ctrl_q;
  logic                    run_prev_q;
  ftec_pkg::ftec_state_t   state_q;
  logic [NCH:0]            det_q;
  logic [NCH-1:0]          det_prev_q;
  logic [2:0]              idx_s_q;
  logic [31:0]             gate_q;
  logic [31:0]             res_q [NCH];
  logic [31:0]             acc_q [NCH];
  logic [31:0]             rd_d;
  logic                    hit;
  logic                    acc_ph;
  logic                    wr_fire;
  logic                    start_p;
  logic                    cnt_en;
  logic                    idx_rise;
  logic                    gate_tick;

  assign acc_ph  = i_apb.psel & i_apb.penable;
  assign wr_fire = acc_ph & i_apb.pwrite & o_pready;

  // Control register write lands on the edge that completes the transfer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ctrl_q <= `FTEC_CTRL_RST;
    end else if (wr_fire && i_apb.paddr == `FTEC_OFS_CTRL) begin
      ctrl_q <= i_apb.pwdata[`FTEC_CTRL_W-1:0];
    end
  end

  always_comb begin
    rd_d = 32'h0;
    hit  = 1'b1;
    case (i_apb.paddr)
      `FTEC_OFS_CTRL: begin
        rd_d = 32'(ctrl_q);
      end
      `FTEC_OFS_STAT: begin
        rd_d = 32'({idx_s_q[2], det_q[NCH-1:0],
                    state_q == ftec_pkg::FTEC_ST_RUN,
                    state_q == ftec_pkg::FTEC_ST_WAIT});
      end
      default: begin
        if (i_apb.paddr[7:4] == `FTEC_CNT_PAGE && i_apb.paddr[1:0] == 2'h0) begin
          rd_d = res_q[i_apb.paddr[3:2]];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // One wait state; read data frozen with pready
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (acc_ph && !o_pready) begin
      o_pready  <= 1'b1;
      o_prdata  <= i_apb.pwrite ? 32'h0 : rd_d;
      o_pslverr <= ~hit;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= ctrl_q[`FTEC_B_RUN];
    end
  end

  assign start_p = ctrl_q[`FTEC_B_RUN] & ~run_prev_q;

  // No trigger input takes part: only run, no-index and the index edge steer this
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state_q <= ftec_pkg::FTEC_ST_IDLE;
    end else if (!ctrl_q[`FTEC_B_RUN]) begin
      state_q <= ftec_pkg::FTEC_ST_IDLE;
    end else if (start_p) begin
      // A missing index track with no-index off holds the wait until run is cleared
      state_q <= ctrl_q[`FTEC_B_NOIDX] ? ftec_pkg::FTEC_ST_RUN : ftec_pkg::FTEC_ST_WAIT;
    end else begin
      case (state_q)
        ftec_pkg::FTEC_ST_WAIT: begin
          if (idx_rise) begin
            state_q <= ftec_pkg::FTEC_ST_RUN;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Single enable for all channels
  assign cnt_en = (state_q == ftec_pkg::FTEC_ST_RUN);

  // Comparators; last one is the index, sharing channel one thresholds
  genvar g;
  generate
    for (g = 0; g <= NCH; g++) begin : g_det
      logic [15:0] smp;
      if (g < NCH) begin : g_trk
        assign smp = i_smp.trk[g];
      end else begin : g_idx
        assign smp = i_smp.idx;
      end
      always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
          det_q[g] <= (g == NCH);
        end else if ($signed(smp) > $signed(16'(`FTEC_RISE_MV))) begin
          det_q[g] <= 1'b1;
        end else if ($signed(smp) < $signed(16'(`FTEC_FALL_MV))) begin
          det_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Reset high so an idle open index gives no false edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      idx_s_q <= `FTEC_IDX_RST;
    end else begin
      idx_s_q <= {idx_s_q[1:0], det_q[NCH]};
    end
  end

  assign idx_rise = idx_s_q[1] & ~idx_s_q[2];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      det_prev_q <= '0;
    end else begin
      det_prev_q <= det_q[NCH-1:0];
    end
  end

  assign gate_tick = (gate_q == 32'(GATE_CYC - 1));

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || start_p || !cnt_en || gate_tick) begin
      gate_q <= 32'h0;
    end else begin
      gate_q <= gate_q + 32'h1;
    end
  end

  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic             dual;
      logic             rise;
      logic             edg;
      logic             up;
      ftec_pkg::ftec_mode_t mode;
      assign dual = ctrl_q[`FTEC_B_DUAL0 + g / 2];
      assign mode = ftec_pkg::ftec_mode_t'(ctrl_q[`FTEC_B_MODE + 2 * g +: 2]);
      // Compared every cycle, so no edge between samples slips past
      assign rise = det_q[g] & ~det_prev_q[g];
      assign edg  = det_q[g] ^ det_prev_q[g];
      assign up   = det_q[g] ^ det_q[g ^ 1];
      always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || start_p) begin
          res_q[g] <= 32'h0;
          acc_q[g] <= 32'h0;
        end else if (dual && (g % 2 == 1)) begin
          res_q[g] <= 32'h0;
          acc_q[g] <= 32'h0;
        end else if (cnt_en && dual) begin
          if (edg) begin
            res_q[g] <= up ? res_q[g] + 32'h1 : res_q[g] - 32'h1;
          end
        end else if (cnt_en) begin
          // Primary track only, never signed
          case (mode)
            ftec_pkg::FTEC_MODE_EVENT: begin
              if (rise) begin
                res_q[g] <= res_q[g] + 32'h1;
              end
            end
            ftec_pkg::FTEC_MODE_FREQ: begin
              if (gate_tick) begin
                res_q[g] <= acc_q[g] + 32'(rise);
                acc_q[g] <= 32'h0;
              end else if (rise) begin
                acc_q[g] <= acc_q[g] + 32'h1;
              end
            end
            ftec_pkg::FTEC_MODE_TIME: begin
              if (rise) begin
                res_q[g] <= acc_q[g] + 32'h1;
                acc_q[g] <= 32'h0;
              end else begin
                acc_q[g] <= acc_q[g] + 32'h1;
              end
            end
            default: begin
              acc_q[g] <= acc_q[g];
            end
          endcase
        end
      end
    end
  endgenerate

endmodule // ftec_counter
`default_nettype wire

//--- sim/ftec_chk_monitor.sv
// Port checker for the encoder counter
`timescale 1ns/1ns
`default_nettype none
module ftec_chk_monitor #(
  parameter int unsigned GATE_CYC = 50
) (
  input wire logic                    i_clk_sys,
  input wire logic                    i_rstn,
  input wire ftec_pkg::ftec_apb_req_t i_apb,
  input wire ftec_pkg::ftec_samples_t i_smp,
  input wire logic [31:0]             o_prdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic acc;
  logic bad;
  assign acc = i_apb.psel && i_apb.penable;
  assign bad = !(i_apb.paddr inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c});
  chk_rdy_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
  chk_rdy_cause: assert property (o_pready |-> acc) else $error("ready outside access");
  chk_rdy_time: assert property (acc && !o_pready |=> o_pready) else $error("ready late");
  chk_idle_quiet: assert property (!acc |=> !o_pready) else $error("ready while idle");
  chk_err_pair: assert property (o_pslverr |-> o_pready) else $error("lone error");
  chk_err_addr: assert property (o_pready |-> o_pslverr == bad) else $error("error flag wrong");
  chk_wr_zero: assert property (o_pready && i_apb.pwrite |-> o_prdata == 32'h0) else $error("write data");
  chk_err_data: assert property (o_pslverr && !i_apb.pwrite |-> o_prdata == 32'h0) else $error("err data");
endmodule // ftec_chk_monitor
bind ftec_counter ftec_chk_monitor #(.GATE_CYC(GATE_CYC)) u_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
  .i_apb(i_apb), .i_smp(i_smp), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
`default_nettype wire

//--- sim/ftec_enc_model.sv
// Quadrature encoder model giving millivolt samples
`timescale 1ns/1ns
`default_nettype none
module ftec_enc_model (
  input  wire logic             i_clk_sys,
  input  wire logic             i_step,
  input  wire logic             i_dir,
  input  wire logic             i_idx_lo,
  input  wire logic [15:0]      i_hi,
  input  wire logic [15:0]      i_lo,
  output var ftec_pkg::ftec_samples_t o_smp
);
  logic [1:0] ph_q = 2'h0;
  always_ff @(posedge i_clk_sys) begin
    if (i_step) ph_q <= i_dir ? ph_q + 2'h1 : ph_q - 2'h1;
  end
  always_comb begin
    o_smp.trk[0] = (ph_q[1] ^ ph_q[0]) ? i_hi : i_lo;
    o_smp.trk[1] = ph_q[1] ? i_hi : i_lo;
    o_smp.trk[2] = (ph_q[1] ^ ph_q[0]) ? i_hi : i_lo;
    o_smp.trk[3] = ph_q[1] ? i_hi : i_lo;
    o_smp.idx = i_idx_lo ? i_lo : i_hi;
  end
endmodule // ftec_enc_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the encoder counter
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x, m) begin checks_done++; if ((g) !== (x)) begin failures++; $display("BAD %0t %s", $time, m); end end
module tb_top;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  ftec_pkg::ftec_apb_req_t apb = '0;
  ftec_pkg::ftec_samples_t smp;
  logic [31:0]             rdat, r;
  logic                    rdy, err, e, step = 1'b0, dir = 1'b0, idx_lo = 1'b0;
  logic [15:0]             hi = 16'h09c4, lo = 16'h0000;
  int                      failures = 0, checks_done = 0, k;
  int                      xe[3] = '{0, 4, 1};
  localparam int           GATE = 50;
  // Two cycles a step, four steps a track period
  localparam int           PER = 8;
  always #5 clk = ~clk;
  ftec_counter #(.GATE_CYC(GATE)) dut (.i_clk_sys(clk), .i_rstn(rstn), .i_apb(apb), .i_smp(smp),
    .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err));
  ftec_enc_model enc (.i_clk_sys(clk), .i_step(step), .i_dir(dir), .i_idx_lo(idx_lo), .i_hi(hi),
    .i_lo(lo), .o_smp(smp));
  function automatic logic [31:0] f_dual(input int c);
    return 32'(2 * c);
  endfunction
  // Steady stepping puts one of two edge counts in any window
  function automatic int f_freq(input int per);
    return GATE / per;
  endfunction
  task automatic apb_x(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) apb.penable <= 1'b1;
    // Only the watchdog ends a stuck wait
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
    e = err;
    apb <= '0;
    @(posedge clk);
  endtask
  task automatic chans(input logic [31:0] x0, input logic [31:0] x1);
    for (int i = 0; i < 4; i++) begin
      apb_x(1'b0, 8'h10 + 8'(4 * i), 32'h0);
      `CHK(r, i[0] ? x1 : x0, "count")
    end
  endtask
  task automatic restart(input logic [31:0] c);
    apb_x(1'b1, 8'h00, 32'h0);
    apb_x(1'b1, 8'h00, c);
  endtask
  task automatic steps(input int c, input logic d);
    repeat (4 * c) begin
      step <= 1'b1;
      dir <= d;
      @(posedge clk);
      step <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic pulse_idx();
    idx_lo <= 1'b1;
    repeat (4) @(posedge clk);
    idx_lo <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Far beyond the several hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(53));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb_x(1'b0, 8'h08, 32'h0);
    `CHK(e, 1'b1, "unmapped")
    $display("test map done");
    restart(32'h1);
    steps(3, 1'b1);
    chans(32'h0, 32'h0);
    apb_x(1'b0, 8'h04, 32'h0);
    `CHK(r, 32'h41, "status wait")
    pulse_idx();
    apb_x(1'b0, 8'h04, 32'h0);
    `CHK(r, 32'h42, "status run")
    k = $urandom_range(8, 1);
    steps(k, 1'b1);
    chans(32'(k), 32'(k));
    restart(32'h1);
    steps(2, 1'b1);
    chans(32'h0, 32'h0);
    pulse_idx();
    $display("test index done");
    restart(32'hf);
    k = $urandom_range(8, 3);
    steps(k, 1'b1);
    chans(f_dual(k), 32'h0);
    steps(k + 2, 1'b0);
    chans(f_dual(-2), 32'h0);
    $display("test dual done");
    // Channel one frequency, two and three time, four event
    restart(32'h293);
    fork
      steps(25, 1'b1);
      begin
        // Read while stepping so the last window is fully busy
        repeat (100) @(posedge clk);
        apb_x(1'b0, 8'h10, 32'h0);
        `CHK(r == f_freq(PER) || r == f_freq(PER) + 1, 1'b1, "freq")
        apb_x(1'b0, 8'h14, 32'h0);
        `CHK(r, 32'(PER), "time")
        apb_x(1'b0, 8'h18, 32'h0);
        `CHK(r, 32'(PER), "time")
      end
    join
    $display("test modes done");
    // Edges sit just past or short of each threshold
    for (int i = 0; i < 3; i++) begin
      hi <= (i == 0) ? 16'h06cc : 16'h06d7 + 16'($urandom_range(1000));
      lo <= (i == 2) ? 16'h0514 : 16'h04e1;
      restart(32'h3);
      steps(4, 1'b1);
      chans(32'(xe[i]), 32'(xe[i]));
    end
    $display("test levels done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
